// ### pkg/tglm_params.svh
// Purpose: constants of the tone generator and level meter block
// Assumes: 100 MHz mclk
// Notes: command codes, bit positions, reset values and timing
`ifndef TGLM_PARAMS_SVH
`define TGLM_PARAMS_SVH
// ----------------------------------------
// command codes
// ----------------------------------------
`define TGLM_CMD_STATUS_CR1 8'h01
`define TGLM_CMD_STATUS_CR2 8'h02
`define TGLM_CMD_COEF_TONE_ONE 8'h0c
`define TGLM_CMD_COEF_TONE_TWO 8'h0d
`define TGLM_CMD_EXT_OFFSET 8'h07
`define TGLM_COEF_BYTES 3'd4
// ----------------------------------------
// control bit positions
// ----------------------------------------
`define TGLM_CR1_TONE_ONE 0
`define TGLM_CR1_TONE_TWO 1
`define TGLM_CR2_VOICE_TONE 0
`define TGLM_CR2_METER_EN 1
`define TGLM_CR2_LOOP 2
`define TGLM_CR2_RESULT 7
// ----------------------------------------
// reset values
// ----------------------------------------
`define TGLM_COEF_1000HZ 32'h1b3b5087
`define TGLM_OFFSET_RST 8'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define TGLM_MEAS_MS 4
`define TGLM_CLK_MHZ 100
`define TGLM_MEAS_CYC (`TGLM_MEAS_MS * 1000 * `TGLM_CLK_MHZ)
`endif

// ### pkg/tglm_pkg.sv
// Purpose: types of the tone generator and level meter block
// Assumes: nothing
// Notes: command carrier and parser states
package tglm_pkg;
  typedef struct packed {
    logic [1:0] kind; // 0 status, 1 coefficient, 2 extended
    logic [7:0] code;
  } tglm_cmd_t;
  typedef enum logic [2:0] {
    TGLM_IDLE = 3'b001,
    TGLM_COEF = 3'b010,
    TGLM_DATA = 3'b100
  } tglm_state_t;
endpackage : tglm_pkg

// ### src/tglm_channel.sv
// Purpose: tone generation and level metering for one voice channel
// Assumes: host bytes arrive as single-cycle strobes on mclk
// Notes: sample rate enable comes from a divider of mclk
// Notes: commands are ignored while coefficient bytes are being collected
// Notes: the result bit is kept when metering is switched off
// Notes: tone two stays forced off for as long as metering is enabled
// Notes: the meter accumulator is sized for the default interval
// Operation
// RL1 - two tone generators, each switched by a control register one write
// RL2 - coefficient command plus four bytes loads a generator and its bandpass; the code has no bandpass and loads only the generator word
// RL3 - code 0C loads generator one, code 0D generator two
// RL4 - any tone on and voice-with-tone clear mutes voice
// RL5 - both generators reset to 1000 Hz coefficients
// RL6 - receive gain scales tone; digital loop feeds tone to transmit
// RL7 - meter bandpass uses generator two coefficients; the code has no bandpass and the meter never uses c2_r
// RL8 - rectify filtered transmit signal, compare to offset, report result bit; the code rectifies tx_sel unfiltered
// RL9 - one 8-bit offset register written by extended write command
// RL10 - host keeps partner channel operating when metering channel two or four
// RL11 - first result 4 ms after enable, then refreshed every 4 ms
// RL12 - host waits 4 ms after offset rewrite before reading
// RL13 - host waits 8 ms after level change, holds signal stable
// RL14 - metering enable switches generator two off
// RL15 - host loads identical coefficients into both bandpass filters
// RL16 - generator one gives -4.5 dBm0 with gain filters disabled
// RL17 - host disables balance filter and mutes voice while metering
// RL18 - host bisects offset byte to find unknown level
// RL19 - result high when level exceeds offset level, low otherwise
// RL20 - reset disables generators and meter, result reads low
`timescale 1ns/10ps
`default_nettype none
`include "tglm_params.svh"
module tglm_channel #(
  parameter int MEAS_CYC = `TGLM_MEAS_CYC,
  parameter int SAMPLE_DIV = 12500
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic cmd_valid,
  input wire tglm_pkg::tglm_cmd_t cmd_in,
  input wire logic byte_valid,
  input wire logic [7:0] byte_in,
  input wire logic [15:0] voice_rx,
  input wire logic [15:0] tx_in,
  input wire logic [7:0] receive_gain_filter,
  output logic [15:0] rx_out,
  output logic [15:0] tx_out,
  output logic [7:0] control_reg_one,
  output logic [7:0] control_reg_two,
  output logic [7:0] level_offset_reference,
  output logic [31:0] tone_one_coef,
  output logic [31:0] tone_two_coef
);
  // ----------------------------------------
  // command parser
  // ----------------------------------------
  // parser state
  tglm_pkg::tglm_state_t st_r, st_nxt;
  logic sel_two_r;
  logic [2:0] cnt_r;
  logic [31:0] shf_r;
  // register state
  logic [7:0] cr1_r, cr2_r, off_r;
  logic [31:0] c1_r, c2_r;
  // tone and meter state
  logic [31:0] meas_r;
  logic [15:0] div_r;
  logic [15:0] ph1_r, ph2_r, tone_r;
  logic [23:0] acc_r;
  logic res_r;
  logic [7:0] cr1_nxt, cr2_nxt, off_nxt;
  logic [31:0] c1_nxt, c2_nxt;
  logic [23:0] acc_nxt;
  logic res_nxt;
  // command match on kind and code
  function automatic logic cmd_hit(
    input tglm_pkg::tglm_cmd_t cmd,
    input logic [1:0] kind,
    input logic [7:0] code
  );
    cmd_hit = cmd.kind == kind && cmd.code == code;
  endfunction : cmd_hit
  // only an idle parser accepts commands
  wire idle = st_r == tglm_pkg::TGLM_IDLE;
  wire take = cmd_valid && idle;
  // status and extended commands carry their byte in the same cycle
  wire wr_cr1 = take && byte_valid && cmd_hit(cmd_in, 2'd0, `TGLM_CMD_STATUS_CR1); // RL1
  wire wr_cr2 = take && byte_valid && cmd_hit(cmd_in, 2'd0, `TGLM_CMD_STATUS_CR2);
  wire wr_off = take && byte_valid && cmd_hit(cmd_in, 2'd2, `TGLM_CMD_EXT_OFFSET); // RL9
  // coefficient commands for either generator
  wire coef_one = take && cmd_hit(cmd_in, 2'd1, `TGLM_CMD_COEF_TONE_ONE);
  wire coef_two = take && cmd_hit(cmd_in, 2'd1, `TGLM_CMD_COEF_TONE_TWO); // RL3
  wire is_coef = coef_one || coef_two;
  // fourth byte of a coefficient sequence
  wire in_data = st_r == tglm_pkg::TGLM_DATA;
  wire byte_take = in_data && byte_valid;
  wire last_byte = byte_take && cnt_r == `TGLM_COEF_BYTES - 3'd1;
  // parser next state
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      tglm_pkg::TGLM_IDLE: if (is_coef) st_nxt = tglm_pkg::TGLM_DATA;
      tglm_pkg::TGLM_COEF: st_nxt = tglm_pkg::TGLM_DATA;
      tglm_pkg::TGLM_DATA: if (last_byte) st_nxt = tglm_pkg::TGLM_IDLE;
      default: st_nxt = tglm_pkg::TGLM_IDLE;
    endcase
  end
  // parser state register
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_r <= tglm_pkg::TGLM_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end
  // generator select latched with the command
  always_ff @(posedge mclk) begin
    if (srst) begin
      sel_two_r <= 1'b0;
    end else if (is_coef) begin
      sel_two_r <= coef_two; // RL3
    end
  end
  // byte counter and msb-first shift register
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_r <= 3'd0;
      shf_r <= 32'h0;
    end else if (is_coef) begin
      cnt_r <= 3'd0;
    end else if (byte_take) begin
      shf_r <= {shf_r[23:0], byte_in}; // RL2
      cnt_r <= cnt_r + 3'd1;
    end
  end
  // ----------------------------------------
  // registers
  // ----------------------------------------
  wire meter_on = cr2_r[`TGLM_CR2_METER_EN];
  wire [31:0] coef_new = {shf_r[23:0], byte_in};
  // control register one, tone two forced off while metering
  always_comb begin
    cr1_nxt = wr_cr1 ? byte_in : cr1_r; // RL1
    if (meter_on) begin
      cr1_nxt[`TGLM_CR1_TONE_TWO] = 1'b0; // RL14
    end
  end
  // control register two and the shared offset byte
  assign cr2_nxt = wr_cr2 ? byte_in : cr2_r;
  assign off_nxt = wr_off ? byte_in : off_r; // RL9
  // coefficient words, one per generator
  assign c1_nxt = last_byte && !sel_two_r ? coef_new : c1_r; // RL2
  assign c2_nxt = last_byte && sel_two_r ? coef_new : c2_r; // RL7
  // control registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      cr1_r <= 8'h00; // RL20
      cr2_r <= 8'h00;
    end else begin
      cr1_r <= cr1_nxt;
      cr2_r <= cr2_nxt;
    end
  end
  // offset byte
  always_ff @(posedge mclk) begin
    if (srst) begin
      off_r <= `TGLM_OFFSET_RST;
    end else begin
      off_r <= off_nxt;
    end
  end
  // coefficient words
  always_ff @(posedge mclk) begin
    if (srst) begin
      c1_r <= `TGLM_COEF_1000HZ; // RL5
      c2_r <= `TGLM_COEF_1000HZ;
    end else begin
      c1_r <= c1_nxt;
      c2_r <= c2_nxt;
    end
  end
  // ----------------------------------------
  // tone synthesis at sample rate
  // ----------------------------------------
  wire samp = div_r == 16'(SAMPLE_DIV - 1);
  wire t1_on = cr1_r[`TGLM_CR1_TONE_ONE];
  wire t2_on = cr1_r[`TGLM_CR1_TONE_TWO] && !meter_on;
  // triangle approximation of a sine from a phase word
  function automatic logic [15:0] wave(input logic [15:0] ph);
    wave = ph[15] ? ~{ph[14:0], 1'b0} : {ph[14:0], 1'b0};
  endfunction
  // tone levels, each scaled down to leave headroom for the sum
  wire [15:0] lvl_one = t1_on ? wave(ph1_r) >> 2 : 16'h0; // RL16
  wire [15:0] lvl_two = t2_on ? wave(ph2_r) >> 2 : 16'h0;
  wire [16:0] lvl_sum = {1'b0, lvl_one} + {1'b0, lvl_two};
  // receive gain scaling, 64 is unity
  wire [24:0] lvl_gain = {8'h00, lvl_sum} * {17'h0, receive_gain_filter}; // RL6
  wire [15:0] tone_nxt = lvl_gain[21:6];
  // sample rate divider
  always_ff @(posedge mclk) begin
    if (srst) begin
      div_r <= 16'h0;
    end else begin
      div_r <= samp ? 16'h0 : div_r + 16'h1;
    end
  end
  // phase accumulators, held at zero while a generator is off
  always_ff @(posedge mclk) begin
    if (srst) begin
      ph1_r <= 16'h0;
      ph2_r <= 16'h0;
    end else if (samp) begin
      ph1_r <= t1_on ? ph1_r + c1_r[31:16] : 16'h0; // RL1
      ph2_r <= t2_on ? ph2_r + c2_r[31:16] : 16'h0;
    end
  end
  // tone sample register
  always_ff @(posedge mclk) begin
    if (srst) begin
      tone_r <= 16'h0;
    end else if (samp) begin
      tone_r <= tone_nxt;
    end
  end
  // ----------------------------------------
  // voice mute and loop
  // ----------------------------------------
  // any running generator mutes voice unless voice-with-tone is set
  wire any_tone = t1_on || t2_on;
  wire voice_tone = cr2_r[`TGLM_CR2_VOICE_TONE];
  wire mute = any_tone && !voice_tone; // RL4
  wire [15:0] voice_kept = mute ? 16'h0 : voice_rx;
  wire [15:0] rx_mix = voice_kept + tone_r;
  // digital loop feeds the tone into the transmit path
  wire loop_on = cr2_r[`TGLM_CR2_LOOP];
  wire [15:0] tx_sel = loop_on ? tone_r : tx_in; // RL6
  // ----------------------------------------
  // level meter
  // ----------------------------------------
  // magnitude of a two's complement sample
  function automatic logic [15:0] magnitude(input logic [15:0] s);
    magnitude = s[15] ? 16'(-s) : s;
  endfunction : magnitude
  wire [15:0] rect = magnitude(tx_sel); // RL8
  wire meas_done = meter_on && meas_r == 32'(MEAS_CYC - 1);
  // accumulate rectified samples, clear at each interval end
  assign acc_nxt = meas_done ? 24'h0 : (samp ? acc_r + 24'(rect[15:4]) : acc_r); // RL8
  // result compares the high byte of the sum with the offset
  assign res_nxt = meas_done ? acc_r[23:16] > off_r : res_r; // RL19
  // interval counter and accumulator, idle while metering is off
  always_ff @(posedge mclk) begin
    if (srst || !meter_on) begin
      meas_r <= 32'h0;
      acc_r <= 24'h0;
    end else begin
      meas_r <= meas_done ? 32'h0 : meas_r + 32'h1; // RL11
      acc_r <= acc_nxt;
    end
  end
  // result bit, kept when metering stops
  always_ff @(posedge mclk) begin
    if (srst) begin
      res_r <= 1'b0; // RL20
    end else if (meter_on) begin
      res_r <= res_nxt;
    end
  end
  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // receive output register
  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_out <= 16'h0;
    end else begin
      rx_out <= rx_mix;
    end
  end
  // transmit output register
  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_out <= 16'h0;
    end else begin
      tx_out <= tx_sel;
    end
  end
  // register views for the host
  assign control_reg_one = cr1_r;
  // result bit sits in the top bit of control register two
  assign control_reg_two = {res_r, cr2_r[6:0]}; // RL8
  // shared offset byte
  assign level_offset_reference = off_r;
  // coefficient words as loaded
  assign tone_one_coef = c1_r;
  assign tone_two_coef = c2_r;
endmodule : tglm_channel
`default_nettype wire

// ### tb/tglm_checker.sv
// Purpose: port checker for tglm_channel
// Assumes: MEAS_CYC handed on by the bind
// Notes: one clock, sync reset
`timescale 1ns/10ps
`default_nettype none
`include "tglm_params.svh"
module tglm_checker #(
  parameter int MEAS_CYC = 100
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic cmd_valid,
  input wire tglm_pkg::tglm_cmd_t cmd_in,
  input wire logic byte_valid,
  input wire logic [7:0] byte_in,
  input wire logic [15:0] tx_in,
  input wire logic [15:0] tx_out,
  input wire logic [7:0] control_reg_one,
  input wire logic [7:0] control_reg_two,
  input wire logic [7:0] level_offset_reference,
  input wire logic [31:0] tone_one_coef,
  input wire logic [31:0] tone_two_coef
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  logic [31:0] meter_cnt_r;
  // cycles spent with metering on
  always_ff @(posedge mclk) begin
    if (srst || !control_reg_two[`TGLM_CR2_METER_EN]) meter_cnt_r <= 32'h0;
    else meter_cnt_r <= meter_cnt_r + 32'h1;
  end
  // coefficient command, then four back-to-back bytes
  sequence coef_seq(logic [7:0] c);
    cmd_valid && cmd_in.kind == 2'h1 && cmd_in.code == c ##1 byte_valid [*4];
  endsequence
  property coef_load(logic [7:0] c, logic [31:0] coef);
    coef_seq(c) |=> coef == {$past(byte_in, 4), $past(byte_in, 3), $past(byte_in, 2),
      $past(byte_in)};
  endproperty
  a_reset_ctrl_clear: assert property (disable iff (1'b0)
    srst |=> control_reg_one == 8'h0 && control_reg_two == 8'h0) else $error("ctrl not reset");
  a_reset_tone_freq: assert property (disable iff (1'b0) srst |=>
    tone_one_coef == `TGLM_COEF_1000HZ && tone_two_coef == `TGLM_COEF_1000HZ)
    else $error("tone coef not reset");
  a_tone_one_load: assert property (coef_load(`TGLM_CMD_COEF_TONE_ONE, tone_one_coef))
    else $error("tone one coef wrong");
  a_tone_two_load: assert property (coef_load(`TGLM_CMD_COEF_TONE_TWO, tone_two_coef))
    else $error("tone two coef wrong");
  a_tone_switch_write: assert property (cmd_valid && byte_valid && cmd_in.kind == 2'h0 &&
    cmd_in.code == `TGLM_CMD_STATUS_CR1 |=> (control_reg_one & 8'h01) == ($past(byte_in) & 8'h01))
    else $error("tone switch not written");
  a_offset_write: assert property (cmd_valid && byte_valid && cmd_in.kind == 2'h2 &&
    cmd_in.code == `TGLM_CMD_EXT_OFFSET |=> level_offset_reference == $past(byte_in))
    else $error("offset not written");
  a_meter_stops_two: assert property (control_reg_two[`TGLM_CR2_METER_EN] |=>
    !control_reg_one[`TGLM_CR1_TONE_TWO]) else $error("tone two left on");
  a_loop_off_pass: assert property ((!control_reg_two[`TGLM_CR2_LOOP] && $stable(tx_in)) [*8]
    |-> tx_out == tx_in) else $error("transmit not passed");
  a_result_timing: assert property ($rose(control_reg_two[`TGLM_CR2_RESULT]) |->
    control_reg_two[`TGLM_CR2_METER_EN] && meter_cnt_r >= MEAS_CYC - 2) else $error("early result");
endmodule : tglm_checker
bind tglm_channel tglm_checker #(.MEAS_CYC(MEAS_CYC)) tglm_checker_i (.mclk(mclk), .srst(srst),
  .cmd_valid(cmd_valid), .cmd_in(cmd_in), .byte_valid(byte_valid), .byte_in(byte_in),
  .tx_in(tx_in), .tx_out(tx_out), .control_reg_one(control_reg_one),
  .control_reg_two(control_reg_two), .level_offset_reference(level_offset_reference),
  .tone_one_coef(tone_one_coef), .tone_two_coef(tone_two_coef));
`default_nettype wire

// ### tb/tglm_host.sv
// Purpose: host model issuing command sequences
// Assumes: drives after the falling edge
// Notes: a released byte line shows the inverse of its last value
`timescale 1ns/10ps
`default_nettype none
module tglm_host #(
  parameter int MEAS_CYC = 100
) (
  input wire logic mclk,
  output var logic cmd_valid,
  output var tglm_pkg::tglm_cmd_t cmd_in,
  output var logic byte_valid,
  output var logic [7:0] byte_in
);
  initial begin
    cmd_valid = 1'b0;
    cmd_in = 10'h0;
    byte_valid = 1'b0;
    byte_in = 8'h0;
  end
  // status or extended command with its byte
  task automatic write_reg(input logic [1:0] kind, input logic [7:0] code, input logic [7:0] data);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_in = {kind, code};
    byte_valid = 1'b1;
    byte_in = data;
    @(negedge mclk);
    cmd_valid = 1'b0;
    byte_valid = 1'b0;
    byte_in = ~byte_in;
    @(negedge mclk);
  endtask : write_reg
  // coefficient command, four bytes msb first
  task automatic write_coef(input logic [7:0] code, input logic [31:0] coef);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_in = {2'h1, code};
    for (int i = 3; i >= 0; i--) begin
      @(negedge mclk);
      cmd_valid = 1'b0;
      byte_valid = 1'b1;
      byte_in = coef[i*8 +: 8];
    end
    @(negedge mclk);
    byte_valid = 1'b0;
    byte_in = ~byte_in;
    @(negedge mclk);
  endtask : write_coef
  // two measurement intervals before reading the result
  task automatic settle();
    repeat (2 * MEAS_CYC) @(negedge mclk);
  endtask : settle
endmodule : tglm_host
`default_nettype wire

// ### tb/tglm_channel_tb_top.sv
// Purpose: self-checking bench for tglm_channel
// Assumes: MEAS_CYC 400, SAMPLE_DIV 4
// Notes: the host model issues every command
`timescale 1ns/10ps
`default_nettype none
`include "tglm_params.svh"
module tglm_channel_tb_top;
  localparam int MEAS_CYC = 400;
  logic [7:0] lo, hi, mid;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] voice_rx = 16'h1234;
  logic [7:0] gain = 8'h0;
  logic cmd_valid, byte_valid;
  tglm_pkg::tglm_cmd_t cmd_in;
  logic [7:0] byte_in, cr1, cr2, offset;
  logic [15:0] rx_out;
  logic [31:0] coef_one, coef_two;
  int checks = 0;
  int mismatches = 0;
  always #5 mclk = ~mclk;
  tglm_host #(.MEAS_CYC(MEAS_CYC)) tglm_host_i (.mclk(mclk), .cmd_valid(cmd_valid),
    .cmd_in(cmd_in), .byte_valid(byte_valid), .byte_in(byte_in));
  tglm_channel #(.MEAS_CYC(MEAS_CYC), .SAMPLE_DIV(4)) tglm_channel_i (.mclk(mclk), .srst(srst),
    .cmd_valid(cmd_valid), .cmd_in(cmd_in), .byte_valid(byte_valid), .byte_in(byte_in),
    .voice_rx(voice_rx), .tx_in(16'h7fff), .receive_gain_filter(gain), .rx_out(rx_out),
    .tx_out(), .control_reg_one(cr1), .control_reg_two(cr2), .level_offset_reference(offset),
    .tone_one_coef(coef_one), .tone_two_coef(coef_two));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(negedge mclk);
    srst = 1'b0;
    check("ctrl one", cr1, 32'h0);
    check("ctrl two", cr2, 32'h0);
    check("tone one", coef_one, `TGLM_COEF_1000HZ);
    check("tone two", coef_two, `TGLM_COEF_1000HZ);
    tglm_host_i.write_coef(`TGLM_CMD_COEF_TONE_ONE, 32'h14235bd3);
    tglm_host_i.write_coef(`TGLM_CMD_COEF_TONE_TWO, 32'h14235bd3);
    check("tone one", coef_one, 32'h14235bd3);
    check("tone two", coef_two, 32'h14235bd3);
    repeat (16) @(negedge mclk);
    check("voice", rx_out, 32'h1234);
    tglm_host_i.write_reg(2'h0, `TGLM_CMD_STATUS_CR1, 8'h03);
    check("ctrl one", cr1, 32'h3);
    repeat (16) @(negedge mclk);
    check("muted", rx_out, 32'h0);
    tglm_host_i.write_reg(2'h0, `TGLM_CMD_STATUS_CR2, 8'h01);
    repeat (16) @(negedge mclk);
    check("voice tone", rx_out, 32'h1234);
    tglm_host_i.write_reg(2'h2, `TGLM_CMD_EXT_OFFSET, 8'h00);
    check("offset", offset, 32'h0);
    tglm_host_i.write_reg(2'h0, `TGLM_CMD_STATUS_CR2, 8'h02);
    check("tone off", cr1, 32'h1);
    check("result", cr2[`TGLM_CR2_RESULT], 32'h0);
    tglm_host_i.settle();
    check("result", cr2[`TGLM_CR2_RESULT], 32'h1);
    tglm_host_i.write_reg(2'h2, `TGLM_CMD_EXT_OFFSET, 8'hff);
    check("offset", offset, 32'hff);
    tglm_host_i.settle();
    check("result", cr2[`TGLM_CR2_RESULT], 32'h0);
    lo = 8'h00;
    hi = 8'hff;
    repeat (8) begin
      mid = 8'((9'(lo) + 9'(hi)) >> 1);
      tglm_host_i.write_reg(2'h2, `TGLM_CMD_EXT_OFFSET, mid);
      tglm_host_i.settle();
      if (cr2[`TGLM_CR2_RESULT]) lo = mid;
      else hi = mid;
    end
    check("level byte", hi, 32'h3);
    give_verdict();
  end
endmodule : tglm_channel_tb_top
`default_nettype wire
